// File: hdlcsi_pkg.sv
// Constants, types and field layout for the HDLC status and interrupt bank
package hdlcsi_pkg;
    // Register offset of the status word
    localparam logic [7:0] HDLC_STATUS_OFFSET = 8'h86;
    // Status bit positions
    localparam int BIT_TX_PACKET_END = 0;
    localparam int BIT_TX_LOW_WM = 2;
    localparam int BIT_RX_HIGH_WM = 4;
    localparam int BIT_RX_PACKET_START = 5;
    localparam int BIT_RX_PACKET_END = 6;
    localparam int BIT_TX_UNDERRUN = 7;
    localparam int BIT_TX_LEVEL_LO = 8;
    localparam int BIT_TX_EMPTY = 12;
    localparam int BIT_RX_OVERRUN = 13;
    localparam int BIT_RX_EMPTY = 14;
    localparam int BIT_RX_ABORT = 15;
    // Which bits are latched events and which may interrupt
    localparam logic [15:0] LATCHED_MASK = 16'hA0E1;
    localparam logic [15:0] IRQ_CAPABLE = 16'hA0F5;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // Byte halves of the status word
    localparam logic [15:0] LOW_HALF = 16'h00FF;
    localparam logic [15:0] HIGH_HALF = 16'hFF00;
    // FIFO geometry and threshold ladder
    localparam int TX_FIFO_DEPTH = 256;
    localparam int LEVEL_STEP = 16;
    localparam int WM_BASE = 16;
    localparam int WM_STEP = 32;
    localparam logic [3:0] LEVEL_MAX = 4'hF;

    // Per-cycle event pulses from the framing engine
    typedef struct packed {
        logic tx_mark_fetch;   // Byte with tx_message_end_mark fetched
        logic tx_fifo_dry;     // Transmit FIFO ran dry mid-packet
        logic tx_fifo_write;   // Byte written into transmit FIFO
        logic rx_open_byte;    // Opening byte of a packet detected
        logic rx_finish;       // Packet finished, good or bad
        logic rx_overflow;     // Receive FIFO overflow attempt
        logic rx_fifo_read;    // Byte read from receive FIFO
        logic rx_ones_run;     // Seven or more ones seen
        logic rx_in_packet;    // Level: packet reception in progress
        logic rx_flag_seen;    // Valid flag sequence detected
    } hdlcsi_event_type;

    // Host read request on the control port
    typedef struct packed {
        logic rd;              // One-cycle read strobe
        logic [7:0] addr;      // Register address
        logic byte_mode;       // 8-bit port mode
        logic byte_hi;         // In byte mode: upper half read
    } hdlcsi_read_type;
endpackage

// File: hdlcsi_status.sv
// HDLC status word, clear-on-read event latches and interrupt gating
`timescale 1ns/10ps
module hdlcsi_status
    import hdlcsi_pkg::*;
#(
    parameter int COUNT_W = 9
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Host control port
    input wire hdlcsi_read_type host_rd_i,
    output logic [15:0] rd_data_o,
    output logic rd_valid_o,
    // Configuration from control and mask registers
    input wire logic [2:0] tx_low_threshold_select_i,
    input wire logic [2:0] rx_high_threshold_select_i,
    input wire logic [15:0] hdlc_irq_mask_i,
    input wire logic master_irq_mask_i,
    // Framing engine events and FIFO fill counts
    input wire hdlcsi_event_type evt_i,
    input wire logic [COUNT_W-1:0] tx_fifo_count_i,
    input wire logic [COUNT_W-1:0] rx_fifo_count_i,
    // Results
    output logic tx_fifo_accept_o,
    output logic tx_send_abort_o,
    output logic irq_o
);
    // Count must hold the full transmit depth
    if (COUNT_W < 9) begin : g_count_check
        $error("COUNT_W too small for 256-byte FIFO");
    end

    // Threshold ladder for a 3-bit select code
    function automatic logic [COUNT_W-1:0] wm_bytes(input logic [2:0] sel);
        wm_bytes = COUNT_W'(WM_BASE + WM_STEP * int'(sel));
    endfunction

    // Event latches and rearm flags
    logic [15:0] latched;
    logic [15:0] next_latched;
    logic udr_armed;
    logic next_udr_armed;
    logic ovr_armed;
    logic next_ovr_armed;
    logic abt_armed;
    logic next_abt_armed;
    // Registered outputs
    logic [15:0] next_rd_data;
    logic next_rd_valid;
    logic next_tx_fifo_accept;
    logic next_tx_send_abort;
    logic next_irq;
    // Live status word and helpers
    logic [15:0] status_now;
    logic [15:0] clear_bits;
    logic [15:0] set_bits;
    logic [3:0] tx_level;
    logic udr_event;
    logic ovr_event;
    logic abt_event;
    logic status_read;

    // Qualified events after rearm gating
    always_comb begin
        udr_event = evt_i.tx_fifo_dry && udr_armed;
        ovr_event = evt_i.rx_overflow && ovr_armed;
        abt_event = evt_i.rx_ones_run && evt_i.rx_in_packet && abt_armed;
        status_read = host_rd_i.rd && (host_rd_i.addr == HDLC_STATUS_OFFSET);
    end

    // Transmit level code, full FIFO pinned to top code
    always_comb begin
        if (tx_fifo_count_i >= COUNT_W'(TX_FIFO_DEPTH - LEVEL_STEP)) begin
            tx_level = LEVEL_MAX;
        end else begin
            tx_level = tx_fifo_count_i[7:4];
        end
    end

    // Assemble the status word from latches and real-time bits
    always_comb begin
        status_now = latched & LATCHED_MASK;
        status_now[BIT_TX_LOW_WM] = tx_fifo_count_i < wm_bytes(tx_low_threshold_select_i);
        status_now[BIT_RX_HIGH_WM] = rx_fifo_count_i > wm_bytes(rx_high_threshold_select_i);
        status_now[BIT_TX_LEVEL_LO +: 4] = tx_level;
        status_now[BIT_TX_EMPTY] = tx_fifo_count_i == '0;
        status_now[BIT_RX_EMPTY] = rx_fifo_count_i == '0;
    end

    // Event set and clear-on-read terms, set wins over clear
    always_comb begin
        set_bits = STATUS_RESET;
        set_bits[BIT_TX_PACKET_END] = evt_i.tx_mark_fetch || udr_event;
        set_bits[BIT_RX_PACKET_START] = evt_i.rx_open_byte;
        set_bits[BIT_RX_PACKET_END] = evt_i.rx_finish;
        set_bits[BIT_TX_UNDERRUN] = udr_event;
        set_bits[BIT_RX_OVERRUN] = ovr_event;
        set_bits[BIT_RX_ABORT] = abt_event;
        clear_bits = STATUS_RESET;
        if (status_read) begin
            // Clear only what this read returned
            clear_bits = latched & LATCHED_MASK;
            if (host_rd_i.byte_mode) begin
                // Byte mode clears only the half read
                clear_bits = clear_bits & (host_rd_i.byte_hi ? HIGH_HALF : LOW_HALF);
            end
        end
        next_latched = ((latched & ~clear_bits) | set_bits) & LATCHED_MASK;
    end

    // Rearm conditions for underrun, overrun and abort
    always_comb begin
        next_udr_armed = udr_armed;
        if (evt_i.tx_fifo_write) begin
            next_udr_armed = 1'b1;
        end else if (udr_event) begin
            next_udr_armed = 1'b0;
        end
        next_ovr_armed = ovr_armed;
        if (evt_i.rx_fifo_read) begin
            next_ovr_armed = 1'b1;
        end else if (ovr_event) begin
            next_ovr_armed = 1'b0;
        end
        next_abt_armed = abt_armed;
        if (evt_i.rx_flag_seen) begin
            next_abt_armed = 1'b1;
        end else if (abt_event) begin
            next_abt_armed = 1'b0;
        end
    end

    // Read data, FIFO accept, abort request and interrupt
    always_comb begin
        next_rd_valid = host_rd_i.rd;
        next_rd_data = STATUS_RESET;
        if (status_read) begin
            next_rd_data = status_now;
        end
        next_tx_fifo_accept = tx_fifo_count_i < COUNT_W'(TX_FIFO_DEPTH);
        next_tx_send_abort = udr_event;
        // Level code and empty bits sit outside the capable set
        next_irq = master_irq_mask_i && |(next_latched_irq(next_latched, status_now) & hdlc_irq_mask_i);
    end

    // Interrupt sources: next latches plus live watermark bits
    function automatic logic [15:0] next_latched_irq(input logic [15:0] lat, input logic [15:0] now);
        next_latched_irq = (lat | (now & ~LATCHED_MASK)) & IRQ_CAPABLE;
    endfunction

    // Register all state and outputs
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            latched <= STATUS_RESET;
            udr_armed <= 1'b0;
            ovr_armed <= 1'b0;
            abt_armed <= 1'b0;
            rd_data_o <= STATUS_RESET;
            rd_valid_o <= 1'b0;
            tx_fifo_accept_o <= 1'b0;
            tx_send_abort_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            latched <= next_latched;
            udr_armed <= next_udr_armed;
            ovr_armed <= next_ovr_armed;
            abt_armed <= next_abt_armed;
            rd_data_o <= next_rd_data;
            rd_valid_o <= next_rd_valid;
            tx_fifo_accept_o <= next_tx_fifo_accept;
            tx_send_abort_o <= next_tx_send_abort;
            irq_o <= next_irq;
        end
    end

    // Named sequences for the clear-on-read checks
    sequence s_status_read;
        status_read && !host_rd_i.byte_mode;
    endsequence

    sequence s_quiet_tx;
        !evt_i.tx_mark_fetch && !udr_event;
    endsequence

    // No new event and no live interrupt source in this cycle
    sequence s_no_irq_cause;
        (set_bits == STATUS_RESET) && ((status_now & ~LATCHED_MASK & IRQ_CAPABLE) == STATUS_RESET);
    endsequence

    a_pkt_end_mark: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        evt_i.tx_mark_fetch |=> latched[BIT_TX_PACKET_END])
        else $error("packet end not latched on mark");

    a_pkt_end_clear: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (s_status_read and s_quiet_tx) |=> !latched[BIT_TX_PACKET_END])
        else $error("packet end not cleared by read");

    a_irq_needs_masks: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        irq_o |-> $past(master_irq_mask_i) && (($past(hdlc_irq_mask_i) & IRQ_CAPABLE) != 16'h0000))
        else $error("interrupt without both masks");

    a_read_data_word: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        status_read |=> rd_valid_o && (rd_data_o[BIT_TX_LOW_WM]
            == ($past(tx_fifo_count_i) < wm_bytes($past(tx_low_threshold_select_i)))))
        else $error("low watermark bit wrong in read data");

    a_underrun_abort: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        udr_event |=> (tx_send_abort_o && latched[BIT_TX_UNDERRUN]) ##1 (!tx_send_abort_o || $past(udr_event)))
        else $error("underrun did not request abort");

    a_underrun_rearm: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (udr_event && !evt_i.tx_fifo_write) |=> !udr_armed)
        else $error("underrun not disarmed");

    a_level_full_code: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        status_read && (tx_fifo_count_i == COUNT_W'(TX_FIFO_DEPTH)) |=> rd_data_o[11:8] == LEVEL_MAX)
        else $error("full FIFO level code wrong");

    a_abort_outside: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (!evt_i.rx_in_packet && !latched[BIT_RX_ABORT]) |=> !latched[BIT_RX_ABORT])
        else $error("abort latched outside packet");

    a_set_wins_clear: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (status_read && evt_i.rx_finish) |=> latched[BIT_RX_PACKET_END])
        else $error("event lost in read cycle");

    a_byte_half_keep: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (status_read && host_rd_i.byte_mode && !host_rd_i.byte_hi && latched[BIT_RX_ABORT])
            |=> latched[BIT_RX_ABORT])
        else $error("upper flag cleared by lower byte read");

    a_tx_accept_full: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (tx_fifo_count_i == COUNT_W'(TX_FIFO_DEPTH)) |=> !tx_fifo_accept_o)
        else $error("full FIFO still accepting");

    // Latched event checks
    a_pkt_end_underrun: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (evt_i.tx_fifo_dry && udr_armed) |=> latched[BIT_TX_PACKET_END])
        else $error("packet end not latched on underrun");

    a_start_latch: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        evt_i.rx_open_byte |=> latched[BIT_RX_PACKET_START])
        else $error("packet start not latched");

    a_start_read_clear: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (status_read && !host_rd_i.byte_mode && !evt_i.rx_open_byte) |=> !latched[BIT_RX_PACKET_START])
        else $error("packet start not cleared by read");

    a_rx_end_latch: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        evt_i.rx_finish |=> latched[BIT_RX_PACKET_END])
        else $error("receive packet end not latched");

    a_rx_end_clear: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (status_read && !host_rd_i.byte_mode && !evt_i.rx_finish) |=> !latched[BIT_RX_PACKET_END])
        else $error("receive packet end not cleared by read");

    a_abort_cause: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        tx_send_abort_o |-> $past(udr_event))
        else $error("abort request without underrun");

    a_overrun_latch: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (evt_i.rx_overflow && ovr_armed) |=> latched[BIT_RX_OVERRUN])
        else $error("overrun not latched");

    a_overrun_rearm: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (ovr_event && !evt_i.rx_fifo_read) |=> !ovr_armed)
        else $error("overrun not disarmed");

    a_abort_latch: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (evt_i.rx_ones_run && evt_i.rx_in_packet && abt_armed) |=> latched[BIT_RX_ABORT])
        else $error("receive abort not latched");

    a_abort_rearm: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (abt_event && !evt_i.rx_flag_seen) |=> !abt_armed)
        else $error("receive abort not disarmed");

    a_byte_low_keep: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (status_read && host_rd_i.byte_mode && host_rd_i.byte_hi && latched[BIT_TX_PACKET_END])
            |=> latched[BIT_TX_PACKET_END])
        else $error("lower flag cleared by upper byte read");

    // Real-time bit checks
    a_low_wm_empty: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (tx_fifo_count_i == '0) |-> status_now[BIT_TX_LOW_WM])
        else $error("low watermark clear with empty FIFO");

    a_low_wm_top: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (tx_fifo_count_i >= COUNT_W'(TX_FIFO_DEPTH - LEVEL_STEP)) |-> !status_now[BIT_TX_LOW_WM])
        else $error("low watermark set above top threshold");

    a_high_wm_low: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (rx_fifo_count_i <= COUNT_W'(WM_BASE)) |-> !status_now[BIT_RX_HIGH_WM])
        else $error("high watermark set below lowest threshold");

    a_level_code_low: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (tx_fifo_count_i < COUNT_W'(LEVEL_STEP)) |-> (tx_level == 4'h0))
        else $error("level code not zero below one step");

    a_empty_in_read: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        status_read |=> (rd_data_o[BIT_TX_EMPTY] == ($past(tx_fifo_count_i) == '0))
            && (rd_data_o[BIT_RX_EMPTY] == ($past(rx_fifo_count_i) == '0)))
        else $error("empty bits wrong in read data");

    // Interrupt checks
    a_live_no_irq: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (hdlc_irq_mask_i == 16'h5F00) |=> !irq_o)
        else $error("interrupt from level or empty bits");

    a_irq_read_release: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        (s_status_read and s_no_irq_cause) |=> !irq_o)
        else $error("interrupt held after clearing read");
endmodule

// File: hdlcsi_host.sv
// Host processor model that issues status reads on the control port
`timescale 1ns/10ps
module hdlcsi_host
    import hdlcsi_pkg::*;
(
    // Clock
    input wire logic clk_sys_i,
    // Read request towards the status bank
    output hdlcsi_read_type host_rd_o
);
    // Port idle at time zero
    initial begin
        host_rd_o = '0;
    end

    // One read strobe, raised after an edge and held through the next
    task automatic do_read(input logic [7:0] addr, input logic bm, input logic hi);
        @(posedge clk_sys_i);
        #1;
        host_rd_o = '{rd: 1'b1, addr: addr, byte_mode: bm, byte_hi: hi};
        @(posedge clk_sys_i);
        #1;
        // Address no longer valid: show a changed pattern, not the old one
        host_rd_o = '{rd: 1'b0, addr: ~addr, byte_mode: bm, byte_hi: ~hi};
    endtask
endmodule

// File: test_hdlcsi_status.sv
// Self-checking bench for the HDLC status word and interrupt gating
`timescale 1ns/10ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_hdlcsi_status;
    import hdlcsi_pkg::*;
    // Event vectors in struct bit order
    localparam logic [9:0] M_MARK = 10'h200;
    localparam logic [9:0] M_DRY = 10'h100;
    localparam logic [9:0] M_WR = 10'h080;
    localparam logic [9:0] M_OPEN = 10'h040;
    localparam logic [9:0] M_FIN = 10'h020;
    localparam logic [9:0] M_OVF = 10'h010;
    localparam logic [9:0] M_RRD = 10'h008;
    localparam logic [9:0] M_ONES = 10'h004;
    localparam logic [9:0] M_FLAG = 10'h001;
    localparam logic [15:0] LIVE_EV = 16'h0100;
    // Design stimulus and results
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    hdlcsi_read_type host_rd;
    logic [15:0] rd_data;
    logic rd_valid;
    logic [2:0] tsel = 3'h0;
    logic [2:0] rsel = 3'h0;
    logic [15:0] imask = 16'h0000;
    logic mmask = 1'b1;
    hdlcsi_event_type evt = '0;
    logic inpk = 1'b0;
    logic [8:0] tcnt = 9'h000;
    logic [8:0] rcnt = 9'h000;
    logic accept;
    logic abort;
    logic irq;
    // Expected read words and byte-half masks, oldest first
    logic [15:0] qe[$];
    logic [15:0] qm[$];
    int fails = 0;
    int cmp_count = 0;
    int aborts = 0;

    hdlcsi_status hdlcsi_status_inst (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .host_rd_i(host_rd),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .tx_low_threshold_select_i(tsel),
        .rx_high_threshold_select_i(rsel), .hdlc_irq_mask_i(imask), .master_irq_mask_i(mmask),
        .evt_i(evt), .tx_fifo_count_i(tcnt), .rx_fifo_count_i(rcnt), .tx_fifo_accept_o(accept),
        .tx_send_abort_o(abort), .irq_o(irq));
    hdlcsi_host hdlcsi_host_inst (.clk_sys_i(clk_sys_i), .host_rd_o(host_rd));

    // Free-running system clock
    initial begin
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // Live part of the status word from counts and threshold codes
    function automatic logic [15:0] live(input logic [8:0] t, input logic [8:0] r);
        logic [15:0] w;
        w = 16'h0000;
        w[2] = t < WM_BASE + WM_STEP * tsel;
        w[4] = r > WM_BASE + WM_STEP * rsel;
        w[11:8] = (t >= 240) ? LEVEL_MAX : t[7:4];
        w[12] = t == 0;
        w[14] = r == 0;
        return w;
    endfunction

    // Note the expected word, then let the host read
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        qe.push_back(e);
        qm.push_back(m);
        hdlcsi_host_inst.do_read(a, m != 16'hFFFF, m == HIGH_HALF);
    endtask

    // One-cycle event pulse, keeping the in-packet level
    task automatic pulse(input logic [9:0] v);
        @(posedge clk_sys_i);
        #1;
        evt = hdlcsi_event_type'(v | {8'h00, inpk, 1'b0});
        @(posedge clk_sys_i);
        #1;
        evt = hdlcsi_event_type'({8'h00, inpk, 1'b0});
    endtask

    // Let registered outputs follow their causes
    task automatic settle();
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask

    // Two events, then a clearing read and a read proving the clear
    task automatic step(input logic [9:0] a, input logic [9:0] b, input logic [15:0] lat);
        pulse(a);
        pulse(b);
        settle();
        `CHK("irq", lat != 16'h0000, irq)
        rd(HDLC_STATUS_OFFSET, LIVE_EV | lat, 16'hFFFF);
        rd(HDLC_STATUS_OFFSET, LIVE_EV, 16'hFFFF);
        settle();
        `CHK("irq", 1'b0, irq)
    endtask

    task automatic end_sim();
        $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Read-data watcher: compare against the oldest note
    always @(negedge clk_sys_i) begin
        if (rd_valid === 1'b1) begin
            `CHK("status", qe[0] & qm[0], rd_data & qm[0])
            void'(qe.pop_front());
            void'(qm.pop_front());
        end
    end

    // Abort pulses counted for the underrun checks
    always @(posedge clk_sys_i) begin
        if (abort === 1'b1) begin
            aborts++;
        end
    end

    // Watchdog against a hang
    initial begin
        #500000;
        fails++;
        end_sim();
    end

    initial begin
        void'($urandom(81457));
        repeat (20) @(posedge clk_sys_i);
        #1;
        arst_n_i = 1'b1;
        // Live bits, thresholds and level code at boundaries and random counts
        imask = 16'h5F14;
        for (int i = 0; i < 12; i++) begin
            tsel = i[2:0];
            rsel = 3'(7 - i);
            tcnt = 9'(WM_BASE + WM_STEP * i[2:0] - i % 2);
            rcnt = 9'(WM_BASE + WM_STEP * rsel + i % 2);
            if (i == 8) tcnt = 9'h100;
            if (i == 9) tcnt = 9'h000;
            if (i == 9) rcnt = 9'h000;
            if (i > 9) tcnt = 9'($urandom_range(0, 256));
            if (i > 9) rcnt = 9'($urandom_range(0, 256));
            settle();
            `CHK("accept", tcnt != 9'h100, accept)
            `CHK("irq", live(tcnt, rcnt) & 16'h0014 ? 1'b1 : 1'b0, irq)
            rd(HDLC_STATUS_OFFSET, live(tcnt, rcnt), 16'hFFFF);
        end
        rd(8'h84, 16'h0000, 16'hFFFF);
        $display("test done: live bits");
        // Latched events with arming conditions
        tsel = 3'h0;
        rsel = 3'h0;
        tcnt = 9'h014;
        rcnt = 9'h005;
        imask = 16'hFFFF;
        step(M_MARK, 10'h000, 16'h0001);
        step(M_OPEN, 10'h000, 16'h0020);
        step(M_FIN, 10'h000, 16'h0040);
        step(M_DRY, 10'h000, 16'h0000);
        step(M_WR, M_DRY, 16'h0081);
        step(M_OVF, 10'h000, 16'h0000);
        step(M_RRD, M_OVF, 16'h2000);
        step(M_FLAG, M_ONES, 16'h0000);
        inpk = 1'b1;
        step(M_FLAG, M_ONES, 16'h8000);
        step(M_ONES, 10'h000, 16'h0000);
        `CHK("aborts", 1, aborts)
        $display("test done: events");
        // Per-bit and master mask gating
        mmask = 1'b0;
        pulse(M_MARK);
        settle();
        `CHK("irq", 1'b0, irq)
        mmask = 1'b1;
        settle();
        `CHK("irq", 1'b1, irq)
        imask = 16'hFFFE;
        settle();
        `CHK("irq", 1'b0, irq)
        imask = 16'h5F00;
        settle();
        `CHK("irq", 1'b0, irq)
        imask = 16'hFFFF;
        rd(HDLC_STATUS_OFFSET, LIVE_EV | 16'h0001, 16'hFFFF);
        $display("test done: masks");
        // Event in the very cycle of the read stays for the next read
        fork
            pulse(M_MARK | M_FIN);
            rd(HDLC_STATUS_OFFSET, LIVE_EV, 16'hFFFF);
        join
        rd(HDLC_STATUS_OFFSET, LIVE_EV | 16'h0041, 16'hFFFF);
        $display("test done: same-cycle event");
        // Byte mode clears only the half that was read
        pulse(M_MARK);
        pulse(M_FLAG);
        pulse(M_ONES);
        rd(HDLC_STATUS_OFFSET, 16'h0001, LOW_HALF);
        rd(HDLC_STATUS_OFFSET, LIVE_EV | 16'h8000, 16'hFFFF);
        pulse(M_MARK);
        pulse(M_FLAG);
        pulse(M_ONES);
        rd(HDLC_STATUS_OFFSET, 16'h8100, HIGH_HALF);
        rd(HDLC_STATUS_OFFSET, LIVE_EV | 16'h0001, 16'hFFFF);
        settle();
        `CHK("pending", 0, qe.size())
        $display("test done: byte mode");
        end_sim();
    end
endmodule
